// ===== hw/sdd_display_ctrl.sv
// Segment display driver: register file, frame timing and panel drive.
//
// Overview of operation
// [R1] Driver runs only while main config bit 7 is one; resets to zero.
// [R2] Writing one to main config bit 6 clears all segment data.
// [R3] Main config bit 5 enables blinking set by blink source and rate.
// [R4] Bit 4 set forces display off in deep sleep; clear follows enable.
// [R5] Main config bit 3 picks base clock: 0 is 2048Hz, 1 is 128Hz.
// [R6] Multiplex field 01/10/11 gives 2x/3x/4x backplanes; 00 reserved.
// [R7] Shared pins: both segments at 2x, second common at 3x, both at 4x.
// [R8] Drives 24 x 4 segments, or 26 x 2 with shared pins as segments.
// [R9] Drive levels from charge pump up to 5V or external ladder.
// [R10] Driver works in every power mode unless forced off.
// [R11] A pin drives segments only when its segment enable bit is set.
// [R12] Clock register sets frame rate from base clock and blink rate from system clock.
// [R13] Blink source: software off, software on, fixed 2 Hz, rate field.
// [R14] Hold ignores data; after release new data shown next frame, done set.
// [R15] Main config bit 2 picks half bias at 0, third bias at 1.
// [R16] Segment memory reached by pointer register then data register.
`timescale 1ns/1ns
`default_nettype none
module sdd_display_ctrl
  import sdd_pkg::*;
#(
  parameter int FAST_DIV = BASE_FAST_CYC,
  parameter int SLOW_DIV = BASE_SLOW_CYC,
  parameter int BLINK_DIV = BLINK_UNIT_CYC
) (
  // Clock, reset and clock enable.
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  // Special function register port.
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_write,
  input wire logic sfr_read,
  output logic [7:0] sfr_rdata,
  // Power state.
  input wire logic deep_sleep_state,
  // Panel drive.
  output logic [NUM_PINS-1:0] seg_out,
  output logic [NUM_PINS-1:0] seg_pin_active,
  output logic [NUM_COMS-1:0] com_out,
  output logic shared_pin_a_is_com,
  output logic shared_pin_b_is_com,
  output logic frame_start,
  output logic display_active,
  // Drive level generator control.
  output logic bias_third,
  output logic charge_pump_on,
  output logic ext_ladder_on,
  output logic [5:0] bias_level
);
  localparam int BASE_W = $clog2(SLOW_DIV + 1) + 1;
  localparam int BLINK_W = $clog2(BLINK_DIV + 1) + 1;

  initial begin
    if (FAST_DIV < 2 || SLOW_DIV < 2 || BLINK_DIV < 2) begin
      $error("sdd_display_ctrl dividers must be at least 2");
    end
    if (FAST_DIV > SLOW_DIV) begin
      $error("sdd_display_ctrl FAST_DIV must not exceed SLOW_DIV");
    end
  end

  // Number of backplanes for a multiplex code; reserved acts as 2x.
  function automatic logic [2:0] backplanes(input logic [1:0] mux);
    case (mux)
      MUX_3X: backplanes = 3'h3;
      MUX_4X: backplanes = 3'h4;
      default: backplanes = 3'h2;
    endcase
  endfunction

  // Register file.
  logic [7:0] main_config;
  logic [7:0] clock_config;
  logic [7:0] segment_pin_enable;
  logic [7:0] segment_pin_enable_2;
  logic [7:0] display_config_x;
  logic invert_enable;
  logic hold;
  logic frame_update_done;
  logic update_pending;
  logic [7:0] segment_memory_pointer;
  logic [7:0] seg_data [SEG_BYTES];
  logic [7:0] seg_shown [SEG_BYTES];

  // Decoded fields.
  logic display_driver_enable;
  logic blink_enable;
  logic sleep_force_off;
  logic base_clock_select;
  logic [1:0] multiplex_level;
  logic [1:0] blink_source;
  logic [1:0] blink_rate_select;
  logic [3:0] frame_divider;

  assign display_driver_enable = main_config[MC_ENABLE_BIT];
  assign blink_enable = main_config[MC_BLINK_BIT];
  assign sleep_force_off = main_config[MC_SLEEP_OFF_BIT];
  assign base_clock_select = main_config[MC_BASE_CLOCK_SELECT_BIT];
  assign multiplex_level = main_config[MC_MUX_LSB +: 2];
  assign blink_source = clock_config[CC_SOURCE_LSB +: 2];
  assign blink_rate_select = clock_config[CC_RATE_LSB +: 2];
  assign frame_divider = clock_config[CC_FRAME_LSB +: 4];

  // Write strobes.
  logic wr_main;
  logic wr_data;
  logic wr_cony;
  logic ptr_valid;
  logic [3:0] ptr_index;
  logic frame_tick;

  assign wr_main = sfr_write && (sfr_addr == ADDR_MAIN_CONFIG);
  assign wr_data = sfr_write && (sfr_addr == ADDR_MEM_DATA);
  assign wr_cony = sfr_write && (sfr_addr == ADDR_CONFIG_Y);
  assign ptr_valid = (segment_memory_pointer < 8'(SEG_BYTES));
  assign ptr_index = segment_memory_pointer[3:0];

  // The clear bit is a command, so it is never stored and reads back zero.
  always_ff @(posedge clk) begin
    if (reset) begin
      main_config <= RST_MAIN_CONFIG;
    end else if (ce && wr_main) begin
      main_config <= sfr_wdata & ~(8'h01 << MC_CLEAR_BIT);
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      clock_config <= RST_CLOCK_CONFIG;
      segment_pin_enable <= RST_PIN_ENABLE;
      segment_pin_enable_2 <= RST_PIN_ENABLE;
      display_config_x <= RST_CONFIG_X;
      segment_memory_pointer <= RST_MEM_POINTER;
    end else if (ce && sfr_write) begin
      if (sfr_addr == ADDR_CLOCK_CONFIG) begin
        clock_config <= sfr_wdata;
      end else if (sfr_addr == ADDR_PIN_ENABLE) begin
        segment_pin_enable <= sfr_wdata;
      end else if (sfr_addr == ADDR_PIN_ENABLE_2) begin
        segment_pin_enable_2 <= sfr_wdata;
      end else if (sfr_addr == ADDR_CONFIG_X) begin
        display_config_x <= sfr_wdata & 8'h7F;
      end else if (sfr_addr == ADDR_MEM_POINTER) begin
        // [R16] Pointer selects location.
        segment_memory_pointer <= sfr_wdata;
      end
    end
  end

  // Working segment memory that software sees.
  always_ff @(posedge clk) begin
    if (reset) begin
      for (int i = 0; i < SEG_BYTES; i++) begin
        seg_data[i] <= 8'h00;
      end
    end else if (ce) begin
      if (wr_main && sfr_wdata[MC_CLEAR_BIT]) begin
        // [R2] Clear all data.
        for (int i = 0; i < SEG_BYTES; i++) begin
          seg_data[i] <= 8'h00;
        end
      end else if (wr_data && ptr_valid) begin
        // [R16] Indirect data write.
        seg_data[ptr_index] <= sfr_wdata;
      end
    end
  end

  // Hold, update pending and done flag.
  always_ff @(posedge clk) begin
    if (reset) begin
      invert_enable <= 1'b0;
      hold <= 1'b0;
      update_pending <= 1'b0;
      frame_update_done <= 1'b0;
    end else if (ce) begin
      if (wr_cony) begin
        invert_enable <= sfr_wdata[CY_INVERT_BIT];
        hold <= sfr_wdata[CY_HOLD_BIT];
      end
      // [R14] Release arms update.
      if (wr_cony && hold && !sfr_wdata[CY_HOLD_BIT]) begin
        update_pending <= 1'b1;
      end else if (frame_tick && !hold) begin
        update_pending <= 1'b0;
      end
      // [R14] Done set wins.
      if (frame_tick && !hold && update_pending) begin
        frame_update_done <= 1'b1;
      end else if (wr_cony && !sfr_wdata[CY_DONE_BIT]) begin
        frame_update_done <= 1'b0;
      end
    end
  end

  // Shown copy is only refreshed at a frame boundary, never mid-frame.
  always_ff @(posedge clk) begin
    if (reset) begin
      for (int i = 0; i < SEG_BYTES; i++) begin
        seg_shown[i] <= 8'h00;
      end
    end else if (ce && frame_tick && !hold) begin
      // [R14] Latch new frame data.
      for (int i = 0; i < SEG_BYTES; i++) begin
        seg_shown[i] <= seg_data[i];
      end
    end
  end

  // Read data, registered one cycle after the read strobe.
  always_ff @(posedge clk) begin
    if (reset) begin
      sfr_rdata <= 8'h00;
    end else if (ce && sfr_read) begin
      if (sfr_addr == ADDR_MAIN_CONFIG) begin
        sfr_rdata <= main_config;
      end else if (sfr_addr == ADDR_CLOCK_CONFIG) begin
        sfr_rdata <= clock_config;
      end else if (sfr_addr == ADDR_PIN_ENABLE) begin
        sfr_rdata <= segment_pin_enable;
      end else if (sfr_addr == ADDR_CONFIG_X) begin
        sfr_rdata <= display_config_x;
      end else if (sfr_addr == ADDR_MEM_POINTER) begin
        sfr_rdata <= segment_memory_pointer;
      end else if (sfr_addr == ADDR_MEM_DATA) begin
        // [R16] Indirect data read.
        sfr_rdata <= ptr_valid ? seg_data[ptr_index] : 8'h00;
      end else if (sfr_addr == ADDR_CONFIG_Y) begin
        sfr_rdata <= {1'b0, invert_enable, 4'h0, frame_update_done, hold};
      end else if (sfr_addr == ADDR_PIN_ENABLE_2) begin
        sfr_rdata <= segment_pin_enable_2;
      end else begin
        sfr_rdata <= 8'h00;
      end
    end
  end

  // Run state.
  sdd_state_e state;
  sdd_state_e next_state;
  logic run_request;

  // [R1] [R4] [R10] Effective enable.
  assign run_request = display_driver_enable &&
                       !(sleep_force_off && deep_sleep_state);

  always_comb begin
    case (state)
      st_off: next_state = run_request ? st_run : st_off;
      st_run: next_state = run_request ? st_run : st_off;
      default: next_state = st_off;
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state <= st_off;
    end else if (ce) begin
      state <= next_state;
    end
  end

  logic running;
  assign running = (state == st_run);

  // Base clock, phase and blink timing.
  logic base_tick;
  logic phase_tick;
  logic blink_unit_tick;
  logic [BASE_W-1:0] base_period;
  logic [6:0] phase_period;
  logic [2:0] phase_mult;
  logic [4:0] frame_steps;

  // [R5] Base clock select.
  assign base_period = base_clock_select ? BASE_W'(SLOW_DIV)
                                         : BASE_W'(FAST_DIV);
  // [R12] Frame divider; a zero field is served as one.
  assign frame_steps = (frame_divider == 4'h0) ? 5'h02
                                               : {1'b0, frame_divider} + 5'h01;
  assign phase_mult = (backplanes(multiplex_level) == 3'h2) ? PHASE_MULT_2X
                                                            : PHASE_MULT_NX;
  assign phase_period = 7'(frame_steps * phase_mult);

  sdd_tick_div #(.WIDTH(BASE_W)) u_base_div (
    .clk(clk),
    .reset(reset),
    .ce(ce),
    .run(running),
    .step(1'b1),
    .period(base_period),
    .tick(base_tick)
  );

  sdd_tick_div #(.WIDTH(7)) u_phase_div (
    .clk(clk),
    .reset(reset),
    .ce(ce),
    .run(running),
    .step(base_tick),
    .period(phase_period),
    .tick(phase_tick)
  );

  // Blink timing runs off the system clock so it is the same at both bases.
  sdd_tick_div #(.WIDTH(BLINK_W)) u_blink_div (
    .clk(clk),
    .reset(reset),
    .ce(ce),
    .run(running && blink_enable),
    .step(1'b1),
    .period(BLINK_W'(BLINK_DIV)),
    .tick(blink_unit_tick)
  );

  // Backplane phase and frame parity.
  logic [1:0] phase;
  logic frame_odd;
  logic [2:0] bp_count;

  // [R6] Backplane count.
  assign bp_count = backplanes(multiplex_level);
  assign frame_tick = phase_tick && ({1'b0, phase} + 3'h1 >= bp_count);

  always_ff @(posedge clk) begin
    if (reset) begin
      phase <= 2'h0;
      frame_odd <= 1'b0;
    end else if (ce) begin
      if (!running) begin
        phase <= 2'h0;
        frame_odd <= 1'b0;
      end else if (frame_tick) begin
        phase <= 2'h0;
        frame_odd <= !frame_odd;
      end else if (phase_tick) begin
        phase <= phase + 2'h1;
      end
    end
  end

  // Blink state: units of a quarter second count out each half period.
  logic [3:0] blink_units;
  logic [3:0] blink_half;
  logic blink_dark;
  logic blank;

  // [R13] Half period in units.
  assign blink_half = (blink_source == BLINK_FIXED) ? 4'h1
                      : {1'b0, blink_rate_select, 1'b0} + 4'h2;

  always_ff @(posedge clk) begin
    if (reset) begin
      blink_units <= 4'h0;
      blink_dark <= 1'b0;
    end else if (ce) begin
      if (!running || !blink_enable) begin
        blink_units <= 4'h0;
        blink_dark <= 1'b0;
      end else if (blink_unit_tick) begin
        if (blink_units + 4'h1 >= blink_half) begin
          blink_units <= 4'h0;
          blink_dark <= !blink_dark;
        end else begin
          blink_units <= blink_units + 4'h1;
        end
      end
    end
  end

  // [R3] [R13] Blanking.
  always_comb begin
    if (!blink_enable) begin
      blank = 1'b0;
    end else begin
      case (blink_source)
        BLINK_SW_OFF: blank = 1'b1;
        BLINK_SW_ON: blank = 1'b0;
        default: blank = blink_dark;
      endcase
    end
  end

  // Shared pin roles and segment pin functions.
  // [R7] Shared pin roles.
  assign shared_pin_a_is_com = (multiplex_level == MUX_4X);
  assign shared_pin_b_is_com = (multiplex_level == MUX_3X) ||
                               (multiplex_level == MUX_4X);

  logic [NUM_PINS-1:0] pin_enable;
  logic [NUM_PINS*NUM_COMS-1:0] shown_flat;

  // [R8] [R11] Pin enable map.
  generate
    for (genvar p = 0; p < NUM_PINS; p++) begin : g_pin
      if (p < 16) begin : g_first
        assign pin_enable[p] = segment_pin_enable[p / 2];
      end else begin : g_second
        assign pin_enable[p] = segment_pin_enable_2[(p - 16) / 2];
      end
    end
    for (genvar b = 0; b < SEG_BYTES; b++) begin : g_flat
      assign shown_flat[b*8 +: 8] = seg_shown[b];
    end
  endgenerate

  assign seg_pin_active[NUM_DEDICATED-1:0] = pin_enable[NUM_DEDICATED-1:0];
  assign seg_pin_active[SHARED_A_PIN] = pin_enable[SHARED_A_PIN] &&
                                        !shared_pin_a_is_com;
  assign seg_pin_active[SHARED_B_PIN] = pin_enable[SHARED_B_PIN] &&
                                        !shared_pin_b_is_com;

  // Panel drive flip-flops; inversion flips every other frame.
  logic polarity;
  logic [NUM_COMS-1:0] com_next;
  logic [NUM_PINS-1:0] seg_next;
  logic frame_tick_q;

  assign polarity = invert_enable && frame_odd;

  always_comb begin
    com_next = '0;
    seg_next = '0;
    if (running && !blank) begin
      com_next[phase] = 1'b1;
      for (int p = 0; p < NUM_PINS; p++) begin
        seg_next[p] = seg_pin_active[p] &&
                      (shown_flat[int'(phase) * NUM_PINS + p] ^ polarity);
      end
    end else if (running) begin
      com_next[phase] = 1'b1;
    end
    if (shared_pin_b_is_com) begin
      seg_next[SHARED_B_PIN] = com_next[2];
    end
    if (shared_pin_a_is_com) begin
      seg_next[SHARED_A_PIN] = com_next[3];
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      seg_out <= '0;
      com_out <= '0;
      frame_tick_q <= 1'b0;
      frame_start <= 1'b0;
    end else if (ce) begin
      seg_out <= seg_next;
      com_out <= com_next;
      // The panel drive lags the phase by one flop, so the pulse waits a
      // cycle to line up with the first backplane and the new frame data.
      frame_tick_q <= frame_tick;
      frame_start <= frame_tick_q && running;
    end
  end

  assign display_active = running;
  // [R15] Bias select.
  assign bias_third = main_config[MC_BIAS_BIT];
  // [R9] Level source.
  assign ext_ladder_on = running && display_config_x[CX_LADDER_BIT];
  assign charge_pump_on = running && !display_config_x[CX_LADDER_BIT];
  assign bias_level = display_config_x[CX_LEVEL_LSB +: 6];
endmodule
`default_nettype wire

// ===== hw/sdd_pkg.sv
// Constants, register map and types for the segment display driver.
`default_nettype none
package sdd_pkg;
  // Clock and time bases.
  localparam int CLK_HZ = 100_000_000;
  localparam int BASE_FAST_HZ = 2048;
  localparam int BASE_SLOW_HZ = 128;
  localparam int BASE_FAST_CYC = CLK_HZ / BASE_FAST_HZ;
  localparam int BASE_SLOW_CYC = CLK_HZ / BASE_SLOW_HZ;
  localparam int BLINK_UNIT_MS = 250;
  localparam int BLINK_UNIT_CYC = (CLK_HZ / 1000) * BLINK_UNIT_MS;

  // Panel geometry.
  localparam int NUM_PINS = 26;
  localparam int NUM_DEDICATED = 24;
  localparam int NUM_COMS = 4;
  localparam int SEG_BYTES = (NUM_PINS * NUM_COMS) / 8;
  localparam int SHARED_A_PIN = 24;
  localparam int SHARED_B_PIN = 25;

  // Register offsets.
  localparam logic [7:0] ADDR_MAIN_CONFIG = 8'h95;
  localparam logic [7:0] ADDR_CLOCK_CONFIG = 8'h96;
  localparam logic [7:0] ADDR_PIN_ENABLE = 8'h97;
  localparam logic [7:0] ADDR_CONFIG_X = 8'h9C;
  localparam logic [7:0] ADDR_MEM_POINTER = 8'hAC;
  localparam logic [7:0] ADDR_MEM_DATA = 8'hAE;
  localparam logic [7:0] ADDR_CONFIG_Y = 8'hB1;
  localparam logic [7:0] ADDR_PIN_ENABLE_2 = 8'hED;

  // Reset values.
  localparam logic [7:0] RST_MAIN_CONFIG = 8'h00;
  localparam logic [7:0] RST_CLOCK_CONFIG = 8'h00;
  localparam logic [7:0] RST_PIN_ENABLE = 8'h00;
  localparam logic [7:0] RST_CONFIG_X = 8'h00;
  localparam logic [7:0] RST_MEM_POINTER = 8'h00;

  // Main configuration fields.
  localparam int MC_ENABLE_BIT = 7;
  localparam int MC_CLEAR_BIT = 6;
  localparam int MC_BLINK_BIT = 5;
  localparam int MC_SLEEP_OFF_BIT = 4;
  localparam int MC_BASE_CLOCK_SELECT_BIT = 3;
  localparam int MC_BIAS_BIT = 2;
  localparam int MC_MUX_LSB = 0;

  // Clock configuration fields.
  localparam int CC_SOURCE_LSB = 6;
  localparam int CC_RATE_LSB = 4;
  localparam int CC_FRAME_LSB = 0;

  // Configuration X and Y fields.
  localparam int CX_LADDER_BIT = 6;
  localparam int CX_LEVEL_LSB = 0;
  localparam int CY_INVERT_BIT = 6;
  localparam int CY_DONE_BIT = 1;
  localparam int CY_HOLD_BIT = 0;

  // Multiplex codes.
  localparam logic [1:0] MUX_RESERVED = 2'h0;
  localparam logic [1:0] MUX_2X = 2'h1;
  localparam logic [1:0] MUX_3X = 2'h2;
  localparam logic [1:0] MUX_4X = 2'h3;

  // Blink source codes.
  localparam logic [1:0] BLINK_SW_OFF = 2'h0;
  localparam logic [1:0] BLINK_SW_ON = 2'h1;
  localparam logic [1:0] BLINK_FIXED = 2'h2;
  localparam logic [1:0] BLINK_RATE = 2'h3;

  // Base-clock ticks per backplane phase for each frame divider step.
  localparam logic [2:0] PHASE_MULT_2X = 3'h4;
  localparam logic [2:0] PHASE_MULT_NX = 3'h2;

  typedef enum logic [1:0] {
    st_off = 2'b01,
    st_run = 2'b10
  } sdd_state_e;
endpackage
`default_nettype wire

// ===== hw/sdd_tick_div.sv
// Step counter that emits a tick every period steps.
`timescale 1ns/1ns
`default_nettype none
module sdd_tick_div #(
  parameter int WIDTH = 8
) (
  // Clock and control.
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  input wire logic run,
  // Counting.
  input wire logic step,
  input wire logic [WIDTH-1:0] period,
  output logic tick
);
  logic [WIDTH-1:0] count;
  logic at_end;

  initial begin
    if (WIDTH < 2) begin
      $error("sdd_tick_div needs WIDTH of at least 2");
    end
  end

  // A period of zero behaves as one so the tick never stalls.
  assign at_end = (count + 1'b1 >= period);
  assign tick = run && step && at_end;

  always_ff @(posedge clk) begin
    if (reset) begin
      count <= '0;
    end else if (ce) begin
      if (!run) begin
        count <= '0;
      end else if (step) begin
        count <= at_end ? '0 : count + 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// ===== verification/sdd_display_properties.sv
// Port-level concurrent checks for the segment display controller.
`timescale 1ns/1ns
`default_nettype none
module sdd_display_properties
  import sdd_pkg::*;
(
  // Clock and register port.
  input wire logic clk,
  input wire logic reset,
  input wire logic sfr_read,
  input wire logic [7:0] sfr_rdata,
  // Panel and level outputs.
  input wire logic [NUM_COMS-1:0] com_out,
  input wire logic shared_pin_a_is_com,
  input wire logic shared_pin_b_is_com,
  input wire logic frame_start,
  input wire logic display_active,
  input wire logic charge_pump_on,
  input wire logic ext_ladder_on
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  sequence s_frame_begin;
    frame_start && display_active;
  endsequence
  sequence s_idle_two;
    !display_active ##1 !display_active;
  endsequence
  property p_shared_order;
    shared_pin_a_is_com |-> shared_pin_b_is_com;
  endproperty
  property p_off_com;
    s_idle_two |-> com_out == '0;
  endproperty
  property p_onehot;
    $onehot0(com_out);
  endproperty
  property p_frame_pulse;
    frame_start |=> !frame_start;
  endproperty
  property p_frame_com;
    frame_start |-> com_out == 4'h1;
  endproperty
  property p_levels;
    !(charge_pump_on && ext_ladder_on);
  endproperty
  property p_read_stands;
    !$past(sfr_read) |-> $stable(sfr_rdata);
  endproperty
  property p_com_stands;
    s_frame_begin |=> $stable(com_out) [*2];
  endproperty
  property p_frame_active;
    frame_start |-> display_active || $past(display_active);
  endproperty
  a_shared_order: assert property (p_shared_order)
    else $error("shared pin roles out of order");
  a_off_com: assert property (p_off_com)
    else $error("backplane driven while off");
  a_onehot: assert property (p_onehot)
    else $error("more than one backplane active");
  a_frame_pulse: assert property (p_frame_pulse)
    else $error("frame start longer than one cycle");
  a_frame_com: assert property (p_frame_com)
    else $error("frame does not begin on first backplane");
  a_levels: assert property (p_levels)
    else $error("pump and ladder both on");
  a_read_stands: assert property (p_read_stands)
    else $error("read data changed without a read");
  a_com_stands: assert property (p_com_stands)
    else $error("backplane phase too short");
  a_frame_active: assert property (p_frame_active)
    else $error("frame while driver stopped");
endmodule
bind sdd_display_ctrl sdd_display_properties u_props (.clk, .reset,
  .sfr_read, .sfr_rdata, .com_out, .shared_pin_a_is_com,
  .shared_pin_b_is_com, .frame_start, .display_active, .charge_pump_on,
  .ext_ladder_on);
`default_nettype wire

// ===== verification/sdd_panel_model.sv
// Passive model of the multiplexed panel that counts frames.
`timescale 1ns/1ns
`default_nettype none
module sdd_panel_model
  import sdd_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic reset,
  // Drive seen on the glass.
  input wire logic [NUM_COMS-1:0] com_out,
  input wire logic frame_start,
  // Observed frame count.
  output int frame_cnt
);
  always_ff @(posedge clk) begin
    if (reset) begin
      frame_cnt <= 0;
    end else if (frame_start && com_out != '0) begin
      frame_cnt <= frame_cnt + 1;
    end
  end
endmodule
`default_nettype wire

// ===== verification/tb_segment_lcd_driver_config.sv
// Self-checking testbench for the segment display controller.
`timescale 1ns/1ns
`default_nettype none
module tb_segment_lcd_driver_config;
  import sdd_pkg::*;
  logic clk = 0, reset = 1, ce = 1, sfr_write = 0, sfr_read = 0;
  logic deep = 0;
  logic [7:0] addr = 8'h00, wdata = 8'h00;
  wire [7:0] sfr_rdata;
  wire [NUM_PINS-1:0] seg_out, seg_act;
  wire [NUM_COMS-1:0] com_out;
  wire pa_com, pb_com, frame_start, active, bias3, pump, ladder;
  wire [5:0] blvl;
  int error_cnt = 0, cmp_count = 0, frames, n;
  always #5 clk = ~clk;
  sdd_display_ctrl #(.FAST_DIV(4), .SLOW_DIV(8), .BLINK_DIV(20)) DUT (
    .clk(clk), .reset(reset), .ce(ce), .sfr_addr(addr),
    .sfr_wdata(wdata), .sfr_write(sfr_write), .sfr_read(sfr_read),
    .sfr_rdata(sfr_rdata), .deep_sleep_state(deep), .seg_out(seg_out),
    .seg_pin_active(seg_act), .com_out(com_out),
    .shared_pin_a_is_com(pa_com), .shared_pin_b_is_com(pb_com),
    .frame_start(frame_start), .display_active(active),
    .bias_third(bias3), .charge_pump_on(pump), .ext_ladder_on(ladder),
    .bias_level(blvl));
  sdd_panel_model u_panel (.clk(clk), .reset(reset), .com_out(com_out),
    .frame_start(frame_start), .frame_cnt(frames));
  task finish_test;
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    addr = a;
    wdata = d;
    sfr_write = 1;
    @(negedge clk);
    sfr_write = 0;
  endtask
  task rchk(input logic [7:0] a, input logic [7:0] e);
    @(negedge clk);
    addr = a;
    sfr_read = 1;
    @(negedge clk);
    sfr_read = 0;
    chk(sfr_rdata, e);
  endtask
  task settle;
    repeat (2) @(negedge clk);
  endtask
  // Waits for the next frame start and returns the cycles it took.
  task wait_frame;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (!frame_start && n < 2000);
    if (n >= 2000) begin
      error_cnt++;
      finish_test();
    end
  endtask
  task t_reset_values;
    rchk(ADDR_MAIN_CONFIG, RST_MAIN_CONFIG);
    rchk(ADDR_CLOCK_CONFIG, RST_CLOCK_CONFIG);
    rchk(ADDR_PIN_ENABLE, RST_PIN_ENABLE);
    rchk(ADDR_CONFIG_X, RST_CONFIG_X);
    rchk(ADDR_MEM_POINTER, RST_MEM_POINTER);
    rchk(8'h00, 8'h00);
    chk(active, 1'b0);
  endtask
  task t_memory;
    wr(ADDR_MEM_POINTER, 8'h02);
    wr(ADDR_MEM_DATA, 8'h5A);
    wr(ADDR_MEM_POINTER, 8'h03);
    wr(ADDR_MEM_DATA, 8'hA5);
    rchk(ADDR_MEM_DATA, 8'hA5);
    wr(ADDR_MEM_POINTER, 8'h02);
    rchk(ADDR_MEM_DATA, 8'h5A);
    rchk(ADDR_MEM_POINTER, 8'h02);
    wr(ADDR_MEM_POINTER, 8'h0D);
    wr(ADDR_MEM_DATA, 8'hFF);
    rchk(ADDR_MEM_DATA, 8'h00);
  endtask
  task t_clear;
    wr(ADDR_MEM_POINTER, 8'h02);
    wr(ADDR_MAIN_CONFIG, 8'h40);
    rchk(ADDR_MEM_DATA, 8'h00);
    rchk(ADDR_MAIN_CONFIG, 8'h00);
  endtask
  task t_mux;
    for (int m = 0; m < 4; m++) begin
      wr(ADDR_MAIN_CONFIG, 8'(m));
      chk(pa_com, m == 3);
      chk(pb_com, m >= 2);
    end
  endtask
  task t_pins;
    wr(ADDR_MAIN_CONFIG, 8'h01);
    wr(ADDR_PIN_ENABLE, 8'h01);
    wr(ADDR_PIN_ENABLE_2, 8'h10);
    chk(seg_act, 26'h3000003);
    wr(ADDR_PIN_ENABLE, 8'h00);
    wr(ADDR_PIN_ENABLE_2, 8'h00);
    chk(seg_act, 26'h0000000);
  endtask
  // Frame period with divider step one: phases * 2 * mult * base cycles.
  task t_frame(input logic [7:0] main, input int exp);
    wr(ADDR_CLOCK_CONFIG, 8'h01);
    wr(ADDR_MAIN_CONFIG, main);
    wait_frame();
    wait_frame();
    wait_frame();
    chk(n, exp);
  endtask
  task t_sleep;
    wr(ADDR_MAIN_CONFIG, 8'h81);
    deep = 1;
    settle();
    chk(active, 1'b1);
    wr(ADDR_MAIN_CONFIG, 8'h91);
    settle();
    chk(active, 1'b0);
    deep = 0;
    settle();
    chk(active, 1'b1);
    wr(ADDR_MAIN_CONFIG, 8'h11);
    settle();
    chk(active, 1'b0);
  endtask
  task t_levels;
    wr(ADDR_MAIN_CONFIG, 8'h85);
    wr(ADDR_CONFIG_X, 8'h55);
    settle();
    chk(bias3, 1'b1);
    chk({pump, ladder, blvl}, 8'h55);
    wr(ADDR_CONFIG_X, 8'h00);
    settle();
    chk({pump, ladder}, 2'h2);
  endtask
  task t_hold;
    wr(ADDR_MAIN_CONFIG, 8'h81);
    wr(ADDR_PIN_ENABLE, 8'h0F);
    wr(ADDR_CONFIG_Y, 8'h01);
    wr(ADDR_MEM_POINTER, 8'h00);
    wr(ADDR_MEM_DATA, 8'hFF);
    rchk(ADDR_CONFIG_Y, 8'h01);
    wr(ADDR_CONFIG_Y, 8'h00);
    wait_frame();
    wait_frame();
    chk(com_out, 4'h1);
    chk(seg_out, 26'h00000FF);
    rchk(ADDR_CONFIG_Y, 8'h02);
    wr(ADDR_CONFIG_Y, 8'h00);
    rchk(ADDR_CONFIG_Y, 8'h00);
    wr(ADDR_CLOCK_CONFIG, 8'h01);
    wr(ADDR_MAIN_CONFIG, 8'hA1);
    wait_frame();
    chk(seg_out, 26'h0000000);
    chk(com_out, 4'h1);
    wr(ADDR_CLOCK_CONFIG, 8'h41);
    wait_frame();
    chk(seg_out, 26'h00000FF);
    chk(frames > 0, 1'b1);
  endtask
  initial begin
    repeat (12) @(negedge clk);
    reset = 0;
    t_reset_values();
    t_memory();
    t_clear();
    t_mux();
    t_pins();
    t_frame(8'h81, 64);
    t_frame(8'h82, 48);
    t_frame(8'h83, 64);
    t_frame(8'h89, 128);
    t_frame(8'h80, 64);
    t_sleep();
    t_levels();
    t_hold();
    finish_test();
  end
endmodule
`default_nettype wire
